// File: low_voltage_and_runaway_reset.sv
// Functional notes
// - Undervoltage sets undervoltage_flag and requests internal reset.
// - Undervoltage detection keeps working in stop mode; its reset ends stop.
// - Undervoltage reset waits until a running RAM write cycle completes.
// - No further undervoltage reset while internal reset is already output.
// - Runaway timer is a 20-bit up-counter on the oscillation clock.
// - Runaway counter starts by itself after power-on reset ends.
// - Timeout after 2^20 clocks without clear requests internal reset.
// - Runaway reset lasts exactly five machine cycles.
// - Recovering from standby extends the detection period by 20 us.
// - Runaway counter does not count while CPU is halted.
// - Writing 0 to runaway_counter_clear_bit zeroes the counter.
// - Counter cleared by any internal reset and by oscillator stop.
// - Counter cleared on entering sleep, timebase timer or watch mode.
`timescale 1ns/10ps
`include "supervisor_defines.svh"
module low_voltage_and_runaway_reset #(
  parameter int unsigned TIMEOUT_CYCLES = `RW_TIMEOUT_CYCLES,
  parameter int unsigned MCYC_CLKS = 1
) (
  // Clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Supply comparator pin
  input wire logic i_undervoltage,
  // CPU and clock controller status
  input wire supervisor_pkg::cpu_mode_t i_mode,
  input wire logic i_standby_recover,
  input wire logic i_osc_stopped,
  input wire logic i_ram_write_busy,
  // Control writes
  input wire logic i_clear_bit_wr,
  input wire logic i_clear_bit_data,
  input wire logic i_flag_clr,
  // Results
  output logic o_internal_reset,
  output logic o_undervoltage_flag,
  output logic o_stop_release,
  output logic [`RW_COUNT_W-1:0] o_runaway_count
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [`RW_COUNT_W-1:0] TIMEOUT_LAST = `RW_COUNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [`RW_EXT_W-1:0] EXT_LAST = `RW_EXT_W'(`RW_EXT_CYCLES - 1);
  localparam logic [`RST_CNT_W-1:0] RST_LAST = `RST_CNT_W'(`RST_MCYCLES * MCYC_CLKS - 1);

  typedef struct packed {
    logic [`RW_COUNT_W-1:0] cnt;
    logic ext_active;
    logic [`RW_EXT_W-1:0] ext_cnt;
    logic rst_active;
    logic [`RST_CNT_W-1:0] rst_cnt;
    logic lv_pending;
    supervisor_pkg::cpu_mode_t prev_mode;
    supervisor_pkg::reset_out_t out;
  } state_t;

  state_t q;
  state_t d;
  logic uv_level;

  // ----------------------------------------
  // Comparator input synchroniser
  // ----------------------------------------
  pin_sync3 u_uv_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_undervoltage),
    .o_level(uv_level)
  );

  // ----------------------------------------
  // Mode decoding
  // ----------------------------------------
  // Spare codes of the 3-bit mode field fall to the default
  function automatic logic is_halt_entry(input supervisor_pkg::cpu_mode_t m);
    unique case (m)
      supervisor_pkg::MODE_SLEEP, supervisor_pkg::MODE_TIMEBASE, supervisor_pkg::MODE_WATCH: begin
        is_halt_entry = 1'h1;
      end
      default: begin
        is_halt_entry = 1'h0;
      end
    endcase
  endfunction

  // Stop halts the CPU too, so only run mode counts
  function automatic logic cpu_runs(input supervisor_pkg::cpu_mode_t m);
    cpu_runs = (m == supervisor_pkg::MODE_RUN);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Decisions of this cycle, kept apart for readability
  logic lv_fire;
  logic rw_fire;
  logic fire;
  logic halt_entry;
  logic clear_write;
  logic cnt_clear;

  always_comb begin
    d = q;
    lv_fire = 1'h0;
    rw_fire = 1'h0;
    d.prev_mode = i_mode;
    d.out.stop_release = 1'h0;

    // ----------------------------------------
    // Undervoltage flag
    // ----------------------------------------
    // Set wins over a clear in the same cycle
    if (i_flag_clr) begin
      d.out.undervoltage_flag = 1'h0;
    end
    if (uv_level) begin
      d.out.undervoltage_flag = 1'h1;
    end

    // ----------------------------------------
    // Low-voltage reset request
    // ----------------------------------------
    // Detection stays live in every mode, stop included
    if (uv_level && !q.rst_active) begin
      d.lv_pending = 1'h1;
    end
    // Request held over a RAM write so a short dip is not lost
    if (q.rst_active) begin
      d.lv_pending = 1'h0;
    end else if ((q.lv_pending || uv_level) && !i_ram_write_busy) begin
      lv_fire = 1'h1;
    end

    // ----------------------------------------
    // Runaway counter
    // ----------------------------------------
    // Only counts while the CPU executes
    if (cpu_runs(i_mode) && !q.rst_active) begin
      if (q.ext_active) begin
        if (q.ext_cnt == EXT_LAST) begin
          rw_fire = 1'h1;
        end else begin
          d.ext_cnt = q.ext_cnt + 1'h1;
        end
      end else if (q.cnt == TIMEOUT_LAST) begin
        // Stretch granted only if recovery is flagged at timeout
        if (i_standby_recover) begin
          d.ext_active = 1'h1;
          d.ext_cnt = '0;
        end else begin
          rw_fire = 1'h1;
        end
      end else begin
        d.cnt = q.cnt + 1'h1;
      end
    end

    // ----------------------------------------
    // Counter clear
    // ----------------------------------------
    fire = lv_fire || rw_fire;
    // Only entry into sleep, timebase or watch clears; entering stop or leaving one does not
    halt_entry = is_halt_entry(i_mode) && (i_mode != q.prev_mode);
    clear_write = i_clear_bit_wr && !i_clear_bit_data;
    cnt_clear = fire || q.rst_active || i_osc_stopped ||
                clear_write ||
                halt_entry;
    if (cnt_clear) begin
      d.cnt = '0;
      d.ext_active = 1'h0;
      d.ext_cnt = '0;
    end

    // ----------------------------------------
    // Reset pulse
    // ----------------------------------------
    // One pulse for both sources; a request inside it is dropped
    if (fire) begin
      d.rst_active = 1'h1;
      d.rst_cnt = RST_LAST;
      d.lv_pending = 1'h0;
      d.out.stop_release = (i_mode == supervisor_pkg::MODE_STOP);
    end else if (q.rst_active) begin
      if (q.rst_cnt == '0) begin
        d.rst_active = 1'h0;
      end else begin
        d.rst_cnt = q.rst_cnt - 1'h1;
      end
    end
    d.out.internal_reset = d.rst_active;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset leaves counter at zero so it starts counting at release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Straight from the state register, no logic after the flops
  assign o_internal_reset = q.out.internal_reset;
  assign o_undervoltage_flag = q.out.undervoltage_flag;
  assign o_stop_release = q.out.stop_release;
  assign o_runaway_count = q.cnt;

endmodule

// File: supervisor_defines.svh
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define RW_COUNT_W 20
`define RW_TIMEOUT_CYCLES (1 << 20)
`define RW_EXT_TIME_NS 20000
`define RW_EXT_CYCLES ((`RW_EXT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RW_EXT_W 8
`define RST_MCYCLES 5
`define RST_CNT_W 8

`endif

// File: supervisor_pkg.sv
package supervisor_pkg;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_TIMEBASE,
    MODE_WATCH,
    MODE_STOP
  } cpu_mode_t;

  typedef struct packed {
    logic internal_reset;
    logic undervoltage_flag;
    logic stop_release;
  } reset_out_t;

endpackage

// File: pin_sync3.sv
`timescale 1ns/10ps
module pin_sync3 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin and filtered level
  input wire logic i_pin,
  output logic o_level
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d = q;
    d.ff1 = i_pin;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    // Change accepted only once stages two and three agree
    if (q.ff2 == q.ff3) begin
      d.level = q.ff3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule

// File: lvr_asserts.sv
`timescale 1ns/10ps
`include "supervisor_defines.svh"
module lvr_asserts #(
  parameter int unsigned TIMEOUT_CYCLES = `RW_TIMEOUT_CYCLES,
  parameter int unsigned MCYC_CLKS = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Status inputs
  input wire logic i_undervoltage,
  input wire supervisor_pkg::cpu_mode_t i_mode,
  input wire logic i_standby_recover,
  input wire logic i_osc_stopped,
  input wire logic i_ram_write_busy,
  // Control writes
  input wire logic i_clear_bit_wr,
  input wire logic i_clear_bit_data,
  input wire logic i_flag_clr,
  // Watched outputs
  input wire logic o_internal_reset,
  input wire logic o_undervoltage_flag,
  input wire logic o_stop_release,
  input wire logic [`RW_COUNT_W-1:0] o_runaway_count
);
  wire rs = o_internal_reset;
  wire [19:0] cnt = o_runaway_count;
  wire q = !(i_clear_bit_wr | i_osc_stopped | rs);
  wire fr = i_mode == supervisor_pkg::MODE_RUN && q && !i_standby_recover;
  wire lp = i_mode inside {[supervisor_pkg::MODE_SLEEP:supervisor_pkg::MODE_WATCH]};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Five cycles holds only for one clock per machine cycle
  sequence five_s;
    rs [*5] ##1 !rs;
  endsequence
  // Only the step onto the last value; a running wake-up stretch parks the count there
  timeout_a: assert property (fr && $changed(cnt) && cnt == TIMEOUT_CYCLES - 1 |=> rs && cnt == 0)
    else $error("late timeout");
  width_a: assert property ($rose(rs) |-> five_s) else $error("bad reset width");
  count_step_a: assert property ($past(i_rst_n) && fr && cnt != TIMEOUT_CYCLES - 1 |=> rs || cnt == $past(cnt) + 20'h1)
    else $error("bad count step");
  clear_write_a: assert property (i_clear_bit_wr && !i_clear_bit_data |=> cnt == 0) else $error("clear lost");
  osc_clear_a: assert property (i_osc_stopped |=> cnt == 0) else $error("osc stop kept count");
  mode_clear_a: assert property ($changed(i_mode) && lp |=> cnt == 0) else $error("mode kept count");
  halt_hold_a: assert property (i_mode == supervisor_pkg::MODE_STOP && q |=> $stable(cnt) || rs)
    else $error("count moved in stop");
  // A dip during the last reset cycle is swallowed by that reset
  uv_flag_a: assert property ($rose(o_undervoltage_flag) |-> rs || $past(rs) || $past(i_ram_write_busy))
    else $error("flag without reset");
  stop_wake_a: assert property (o_stop_release == ($rose(rs) && $past(i_mode) == supervisor_pkg::MODE_STOP))
    else $error("stop release mismatch");
endmodule
bind low_voltage_and_runaway_reset lvr_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .MCYC_CLKS(MCYC_CLKS)
) i_lvr_asserts (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_undervoltage(i_undervoltage),
  .i_mode(i_mode),
  .i_standby_recover(i_standby_recover),
  .i_osc_stopped(i_osc_stopped),
  .i_ram_write_busy(i_ram_write_busy),
  .i_clear_bit_wr(i_clear_bit_wr),
  .i_clear_bit_data(i_clear_bit_data),
  .i_flag_clr(i_flag_clr),
  .o_internal_reset(o_internal_reset),
  .o_undervoltage_flag(o_undervoltage_flag),
  .o_stop_release(o_stop_release),
  .o_runaway_count(o_runaway_count)
);

// File: low_voltage_and_runaway_reset_test.sv
`timescale 1ns/10ps
module low_voltage_and_runaway_reset_test;
  localparam int T = 64;
  logic i_clk = 0, i_rst_n = 0, i_undervoltage = 0, i_standby_recover = 0, i_osc_stopped = 0;
  logic i_ram_write_busy = 0, i_clear_bit_wr = 0, i_clear_bit_data = 0, i_flag_clr = 0;
  logic o_internal_reset, o_undervoltage_flag, o_stop_release;
  logic [19:0] o_runaway_count;
  supervisor_pkg::cpu_mode_t i_mode = supervisor_pkg::MODE_RUN;
  int n_fail = 0, n_compared = 0, cyc = 0, k;
  always #50 i_clk = ~i_clk;
  low_voltage_and_runaway_reset #(.TIMEOUT_CYCLES(T)) i_low_voltage_and_runaway_reset (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_undervoltage(i_undervoltage),
    .i_mode(i_mode),
    .i_standby_recover(i_standby_recover),
    .i_osc_stopped(i_osc_stopped),
    .i_ram_write_busy(i_ram_write_busy),
    .i_clear_bit_wr(i_clear_bit_wr),
    .i_clear_bit_data(i_clear_bit_data),
    .i_flag_clr(i_flag_clr),
    .o_internal_reset(o_internal_reset),
    .o_undervoltage_flag(o_undervoltage_flag),
    .o_stop_release(o_stop_release),
    .o_runaway_count(o_runaway_count)
  );
  task automatic results;
    $display("%0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run needs about four hundred and fifty cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results;
    end
  end
  task automatic check(input logic [19:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic t_timeout(input logic ext);
    tick(10);
    #1 check(o_runaway_count != 0, 1);
    tick(1);
    i_clear_bit_wr <= 1;
    i_standby_recover <= ext;
    tick(1);
    i_clear_bit_wr <= 0;
    #1;
    for (k = 0; k < 400 && o_internal_reset !== 1'h1; k++) begin
      tick(1);
      #1;
    end
    // Wake-up stretch of 20 us is 200 cycles at 100 ns
    check(k, ext ? T + 200 : T);
    tick(4);
    #1 check(o_internal_reset, 1);
    tick(1);
    #1 check(o_internal_reset, 0);
    $display("timeout test done");
  endtask
  task automatic t_modes;
    for (int i = 1; i < 5; i++) begin
      tick(10);
      if (i < 4) i_mode <= supervisor_pkg::cpu_mode_t'(i);
      else i_osc_stopped <= 1;
      tick(2);
      #1 check(o_runaway_count, 0);
      tick(1);
      i_mode <= supervisor_pkg::MODE_RUN;
      i_osc_stopped <= 0;
    end
    $display("mode test done");
  endtask
  task automatic t_lowvolt;
    logic [1:0] seen = 0;
    tick(1);
    i_mode <= supervisor_pkg::MODE_STOP;
    i_ram_write_busy <= 1;
    i_undervoltage <= 1;
    tick(10);
    #1 check(o_internal_reset, 0);
    tick(1);
    i_ram_write_busy <= 0;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      i_undervoltage <= 0;
      #1 seen = seen | {o_internal_reset, o_stop_release};
    end
    check(seen, 2'h3);
    check(o_undervoltage_flag, 1);
    tick(1);
    i_mode <= supervisor_pkg::MODE_RUN;
    i_flag_clr <= 1;
    tick(1);
    i_flag_clr <= 0;
    #1 check(o_undervoltage_flag, 0);
    $display("low voltage test done");
  endtask
  initial begin
    tick(2);
    i_rst_n <= 1;
    t_timeout(1);
    t_timeout(0);
    t_modes;
    t_lowvolt;
    results;
  end
endmodule
